// ==== branch_trace_and_store_unit.sv ====
// Overview of operation
// - with trace enabled, every branch, interrupt or exception emits a branch message, except records dropped when the interrupting store is full
// - branch coinciding with interrupt/exception: branch message first, then the other
// - recent-branch stack keeps filling while messages are sent or stored
// - last-exception pair holds the last branch taken before an exception/interrupt
// - last-exception values are 64 bits; only low 32 kept outside extended mode
// - 64-bit sub-mode keeps full addresses; compatibility sub-mode clears upper 32
// - branch store writes records to a memory buffer, circular or interrupting
// - identification feature bit 21 reports that the save area mechanism exists
// - absent flag clear means store present; only then store bits are writable
// - trace message enable sits at debug control bit 2
// - store-full interrupt control at bit 4; clear means circular logging
// - store flag picks bus or buffer as destination, never both
// - store interrupt raised when buffer index reaches or passes the threshold
`timescale 1ns/10ps
module branch_trace_and_store_unit #(
  parameter bit STORE_PRESENT = 1'b1,
  parameter int STACK_DEPTH = 4
) (
  input wire logic clk_sys, // system clock, 40 MHz
  input wire logic rst, // synchronous reset, active high
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [7:0] reg_addr, // register byte address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [31:0] reg_rdata, // read data, cycle after the strobe
  input wire logic mode_ext64, // extended 64-bit mode active
  input wire logic mode_sub64, // 64-bit sub-mode (else compatibility)
  input wire logic br_valid, // taken branch event
  input wire logic [63:0] br_from, // branch source address
  input wire logic [63:0] br_to, // branch target address
  input wire logic xc_valid, // interrupt or exception event
  input wire logic xc_is_int, // event is an interrupt
  input wire logic [63:0] xc_from, // interrupt/exception source address
  input wire logic [63:0] xc_to, // handler address
  output logic ev_ready, // events are taken this cycle
  output logic msg_valid, // branch message on the system bus
  output logic [63:0] rec_from, // record source address
  output logic [63:0] rec_to, // record target address
  output logic [1:0] rec_kind, // record kind
  output logic store_wr, // record written to the store buffer
  output logic [63:0] store_addr, // linear address of the record
  output logic store_irq // store buffer threshold interrupt, level
);

  localparam int PTR_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  trace_store_pkg::seq_state_type state_q, state_d;
  logic [63:0] pend_from_q, pend_from_d, pend_to_q, pend_to_d;
  logic [1:0] pend_kind_q, pend_kind_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [63:0] save_ptr_q, save_ptr_d;
  logic [63:0] ler_src_q, ler_src_d, ler_tgt_q, ler_tgt_d;
  logic [63:0] last_from_q, last_from_d, last_to_q, last_to_d;
  logic [63:0] base_q, base_d;
  logic [31:0] index_q, index_d, absmax_q, absmax_d, thresh_q, thresh_d;
  logic [7:0] sel_q, sel_d;
  logic [PTR_W-1:0] top_q, top_d;
  logic msg_valid_q, msg_valid_d, store_wr_q, store_wr_d, irq_q, irq_d;
  logic [63:0] rec_from_q, rec_from_d, rec_to_q, rec_to_d, store_addr_q, store_addr_d;
  logic [1:0] rec_kind_q, rec_kind_d;
  logic [31:0] rdata_q, rdata_d;
  logic push;
  logic emit;
  logic [63:0] cur_from, cur_to;
  logic [1:0] cur_kind;
  logic [31:0] nidx;
  logic [31:0] rd_word;
  logic [31:0] stack_word;
  logic [127:0] stack_rdata;

  function automatic logic [63:0] fmt_addr(input logic [63:0] a, input logic ext,
                                           input logic sub64);
    fmt_addr = (ext && sub64) ? a : {32'h00000000, a[31:0]};
  endfunction

  // true when a record starting at idx ends at or below lim
  function automatic logic rec_fits(input logic [31:0] idx, input logic [31:0] lim);
    logic [32:0] sum;
    sum = {1'b0, idx} + {1'b0, trace_store_pkg::REC_BYTES};
    rec_fits = (sum <= {1'b0, lim});
  endfunction

  assign ev_ready = ce && (state_q == trace_store_pkg::ST_IDLE);

  recent_branch_stack_mem #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(128),
    .PTR_W(PTR_W)
  ) u_stack (
    .clk_sys(clk_sys),
    .ce(ce),
    .we(push),
    .waddr(PTR_W'(top_q + 1'b1)),
    .wdata({cur_to, cur_from}),
    .raddr(sel_q[trace_store_pkg::SEL_ENTRY_LSB +: PTR_W]),
    .rdata_q(stack_rdata)
  );

  always_comb begin
    case (sel_q[1:0])
      2'h0: stack_word = stack_rdata[31:0];
      2'h1: stack_word = stack_rdata[63:32];
      2'h2: stack_word = stack_rdata[95:64];
      default: stack_word = stack_rdata[127:96];
    endcase
  end

  always_comb begin
    case (reg_addr)
      trace_store_pkg::OFS_DEBUG_CTRL: rd_word = ctrl_q;
      trace_store_pkg::OFS_MISC_FEATURE:
        rd_word = 32'(!STORE_PRESENT) << trace_store_pkg::BIT_ABSENT;
      trace_store_pkg::OFS_IDENT_FEATURE:
        rd_word = 32'(STORE_PRESENT) << trace_store_pkg::BIT_SAVE_FEATURE;
      trace_store_pkg::OFS_SAVE_PTR_LO: rd_word = save_ptr_q[31:0];
      trace_store_pkg::OFS_SAVE_PTR_HI: rd_word = save_ptr_q[63:32];
      trace_store_pkg::OFS_LER_SRC_LO: rd_word = ler_src_q[31:0];
      trace_store_pkg::OFS_LER_SRC_HI: rd_word = ler_src_q[63:32];
      trace_store_pkg::OFS_LER_TGT_LO: rd_word = ler_tgt_q[31:0];
      trace_store_pkg::OFS_LER_TGT_HI: rd_word = ler_tgt_q[63:32];
      trace_store_pkg::OFS_BUF_BASE_LO: rd_word = base_q[31:0];
      trace_store_pkg::OFS_BUF_BASE_HI: rd_word = base_q[63:32];
      trace_store_pkg::OFS_BUF_INDEX: rd_word = index_q;
      trace_store_pkg::OFS_BUF_ABSMAX: rd_word = absmax_q;
      trace_store_pkg::OFS_BUF_THRESH: rd_word = thresh_q;
      trace_store_pkg::OFS_STACK_SEL: rd_word = {24'h000000, sel_q};
      trace_store_pkg::OFS_STACK_DATA: rd_word = stack_word;
      trace_store_pkg::OFS_STACK_TOP: rd_word = 32'(top_q);
      default: rd_word = 32'h00000000;
    endcase
  end

  always_comb begin
    state_d = state_q;
    pend_from_d = pend_from_q;
    pend_to_d = pend_to_q;
    pend_kind_d = pend_kind_q;
    ctrl_d = ctrl_q;
    save_ptr_d = save_ptr_q;
    ler_src_d = ler_src_q;
    ler_tgt_d = ler_tgt_q;
    last_from_d = last_from_q;
    last_to_d = last_to_q;
    base_d = base_q;
    index_d = index_q;
    absmax_d = absmax_q;
    thresh_d = thresh_q;
    sel_d = sel_q;
    top_d = top_q;
    msg_valid_d = 1'b0;
    store_wr_d = 1'b0;
    rec_from_d = rec_from_q;
    rec_to_d = rec_to_q;
    rec_kind_d = rec_kind_q;
    store_addr_d = store_addr_q;
    push = 1'b0;
    emit = 1'b0;
    cur_from = fmt_addr(br_from, mode_ext64, mode_sub64);
    cur_to = fmt_addr(br_to, mode_ext64, mode_sub64);
    cur_kind = trace_store_pkg::KIND_BRANCH;
    nidx = index_q + trace_store_pkg::REC_BYTES;
    rdata_d = reg_rd ? rd_word : 32'h00000000;

    unique case (state_q)
      trace_store_pkg::ST_IDLE: begin
        if (br_valid) begin
          emit = 1'b1;
          if (xc_valid) begin
            pend_from_d = fmt_addr(xc_from, mode_ext64, mode_sub64);
            pend_to_d = fmt_addr(xc_to, mode_ext64, mode_sub64);
            pend_kind_d = xc_is_int ? trace_store_pkg::KIND_INTERRUPT :
                                      trace_store_pkg::KIND_EXCEPTION;
            state_d = trace_store_pkg::ST_SECOND;
          end
        end else if (xc_valid) begin
          emit = 1'b1;
          cur_from = fmt_addr(xc_from, mode_ext64, mode_sub64);
          cur_to = fmt_addr(xc_to, mode_ext64, mode_sub64);
          cur_kind = xc_is_int ? trace_store_pkg::KIND_INTERRUPT :
                                 trace_store_pkg::KIND_EXCEPTION;
        end
      end
      trace_store_pkg::ST_SECOND: begin
        emit = 1'b1;
        cur_from = pend_from_q;
        cur_to = pend_to_q;
        cur_kind = pend_kind_q;
        state_d = trace_store_pkg::ST_IDLE;
      end
    endcase

    if (emit) begin
      if (cur_kind == trace_store_pkg::KIND_BRANCH) begin
        last_from_d = cur_from;
        last_to_d = cur_to;
      end else begin
        // a coincident branch was latched one cycle earlier, so it is the last one
        ler_src_d = last_from_q;
        ler_tgt_d = last_to_q;
      end
      // trace alone keeps the stack moving; messages take the event itself, not the stack
      if (ctrl_q[trace_store_pkg::BIT_RECENT] || ctrl_q[trace_store_pkg::BIT_TRACE]) begin
        push = 1'b1;
        top_d = PTR_W'(top_q + 1'b1);
      end
      if (ctrl_q[trace_store_pkg::BIT_TRACE]) begin
        rec_from_d = cur_from;
        rec_to_d = cur_to;
        rec_kind_d = cur_kind;
        if (!ctrl_q[trace_store_pkg::BIT_STORE]) begin
          msg_valid_d = 1'b1;
        end else if (!ctrl_q[trace_store_pkg::BIT_FULLINT] || rec_fits(index_q, absmax_q)) begin
          // interrupt mode drops records that would pass the absolute maximum
          store_wr_d = 1'b1;
          store_addr_d = base_q + {32'h00000000, index_q};
          index_d = (!ctrl_q[trace_store_pkg::BIT_FULLINT] && !rec_fits(nidx, absmax_q)) ?
                    32'h00000000 : nidx;
        end
      end
    end

    // a software write to the index overrides the advance of the same cycle
    if (reg_wr) begin
      case (reg_addr)
        trace_store_pkg::OFS_DEBUG_CTRL:
          ctrl_d = reg_wdata & trace_store_pkg::CTRL_WMASK &
                   (STORE_PRESENT ? 32'hffffffff : ~trace_store_pkg::STORE_BITS_MASK);
        trace_store_pkg::OFS_SAVE_PTR_LO: save_ptr_d[31:0] = reg_wdata;
        trace_store_pkg::OFS_SAVE_PTR_HI: save_ptr_d[63:32] = reg_wdata;
        trace_store_pkg::OFS_BUF_BASE_LO: base_d[31:0] = reg_wdata;
        trace_store_pkg::OFS_BUF_BASE_HI: base_d[63:32] = reg_wdata;
        trace_store_pkg::OFS_BUF_INDEX: index_d = reg_wdata;
        trace_store_pkg::OFS_BUF_ABSMAX: absmax_d = reg_wdata;
        trace_store_pkg::OFS_BUF_THRESH: thresh_d = reg_wdata;
        trace_store_pkg::OFS_STACK_SEL: sel_d = reg_wdata[7:0];
        default: ;
      endcase
    end

    irq_d = ctrl_d[trace_store_pkg::BIT_TRACE] && ctrl_d[trace_store_pkg::BIT_STORE] &&
            ctrl_d[trace_store_pkg::BIT_FULLINT] && (index_d >= thresh_d);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= trace_store_pkg::ST_IDLE;
      pend_from_q <= trace_store_pkg::RST_ADDR;
      pend_to_q <= trace_store_pkg::RST_ADDR;
      pend_kind_q <= trace_store_pkg::KIND_BRANCH;
      ctrl_q <= trace_store_pkg::RST_WORD;
      save_ptr_q <= trace_store_pkg::RST_ADDR;
      ler_src_q <= trace_store_pkg::RST_ADDR;
      ler_tgt_q <= trace_store_pkg::RST_ADDR;
      last_from_q <= trace_store_pkg::RST_ADDR;
      last_to_q <= trace_store_pkg::RST_ADDR;
      base_q <= trace_store_pkg::RST_ADDR;
      index_q <= trace_store_pkg::RST_WORD;
      absmax_q <= trace_store_pkg::RST_WORD;
      thresh_q <= trace_store_pkg::RST_WORD;
      sel_q <= trace_store_pkg::RST_SEL;
      top_q <= '0;
      msg_valid_q <= 1'b0;
      store_wr_q <= 1'b0;
      irq_q <= 1'b0;
      rec_from_q <= trace_store_pkg::RST_ADDR;
      rec_to_q <= trace_store_pkg::RST_ADDR;
      rec_kind_q <= trace_store_pkg::KIND_BRANCH;
      store_addr_q <= trace_store_pkg::RST_ADDR;
      rdata_q <= trace_store_pkg::RST_WORD;
    end else if (ce) begin
      state_q <= state_d;
      pend_from_q <= pend_from_d;
      pend_to_q <= pend_to_d;
      pend_kind_q <= pend_kind_d;
      ctrl_q <= ctrl_d;
      save_ptr_q <= save_ptr_d;
      ler_src_q <= ler_src_d;
      ler_tgt_q <= ler_tgt_d;
      last_from_q <= last_from_d;
      last_to_q <= last_to_d;
      base_q <= base_d;
      index_q <= index_d;
      absmax_q <= absmax_d;
      thresh_q <= thresh_d;
      sel_q <= sel_d;
      top_q <= top_d;
      msg_valid_q <= msg_valid_d;
      store_wr_q <= store_wr_d;
      irq_q <= irq_d;
      rec_from_q <= rec_from_d;
      rec_to_q <= rec_to_d;
      rec_kind_q <= rec_kind_d;
      store_addr_q <= store_addr_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign msg_valid = msg_valid_q;
  assign store_wr = store_wr_q;
  assign store_irq = irq_q;
  assign rec_from = rec_from_q;
  assign rec_to = rec_to_q;
  assign rec_kind = rec_kind_q;
  assign store_addr = store_addr_q;

  property p_msg_on_branch;
    @(posedge clk_sys) disable iff (rst)
    (ev_ready && br_valid && ctrl_q[trace_store_pkg::BIT_TRACE] &&
     !ctrl_q[trace_store_pkg::BIT_STORE]) |=> msg_valid && rec_kind == 2'h0;
  endproperty
  a_msg_on_branch: assert property (p_msg_on_branch) else $error("branch gave no message");

  property p_pair_order;
    @(posedge clk_sys) disable iff (rst)
    (ev_ready && br_valid && xc_valid && ctrl_q[trace_store_pkg::BIT_TRACE] &&
     !ctrl_q[trace_store_pkg::BIT_STORE]) ##1 ce |=> msg_valid && rec_kind != 2'h0;
  endproperty
  a_pair_order: assert property (p_pair_order) else $error("second pair message missing");

  property p_stack_push;
    @(posedge clk_sys) disable iff (rst)
    (ev_ready && br_valid && ctrl_q[trace_store_pkg::BIT_TRACE]) |=>
      top_q == PTR_W'($past(top_q) + 1'b1);
  endproperty
  a_stack_push: assert property (p_stack_push) else $error("stack did not advance");

  property p_ler_capture;
    @(posedge clk_sys) disable iff (rst)
    (ce && state_q == trace_store_pkg::ST_SECOND) |=>
      ler_src_q == $past(last_from_q) && ler_tgt_q == $past(last_to_q);
  endproperty
  a_ler_capture: assert property (p_ler_capture) else $error("last exception not captured");

  property p_low_half_only;
    @(posedge clk_sys) disable iff (rst)
    (ev_ready && br_valid && !mode_ext64) |=> last_from_q[63:32] == 32'h00000000;
  endproperty
  a_low_half_only: assert property (p_low_half_only) else $error("upper half kept");

  property p_full_in_sub64;
    @(posedge clk_sys) disable iff (rst)
    (ev_ready && br_valid && mode_ext64 && mode_sub64) |=> last_to_q == $past(br_to);
  endproperty
  a_full_in_sub64: assert property (p_full_in_sub64) else $error("64-bit address cut");

  property p_feature_bit;
    @(posedge clk_sys) disable iff (rst)
    (ce && reg_rd && reg_addr == trace_store_pkg::OFS_IDENT_FEATURE) |=>
      reg_rdata[21] == STORE_PRESENT;
  endproperty
  a_feature_bit: assert property (p_feature_bit) else $error("feature bit wrong");

  property p_store_locked;
    @(posedge clk_sys) disable iff (rst)
    STORE_PRESENT || (ctrl_q & trace_store_pkg::STORE_BITS_MASK) == 32'h00000000;
  endproperty
  a_store_locked: assert property (p_store_locked) else $error("store bits set while absent");

  property p_one_destination;
    @(posedge clk_sys) disable iff (rst)
    !(msg_valid && store_wr);
  endproperty
  a_one_destination: assert property (p_one_destination) else $error("both destinations");

  property p_irq_cause;
    @(posedge clk_sys) disable iff (rst)
    store_irq |-> index_q >= thresh_q && ctrl_q[trace_store_pkg::BIT_FULLINT];
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without threshold");

endmodule // branch_trace_and_store_unit

// ==== trace_store_pkg.sv ====
package trace_store_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFS_DEBUG_CTRL = 8'h00;
  localparam logic [7:0] OFS_MISC_FEATURE = 8'h04;
  localparam logic [7:0] OFS_IDENT_FEATURE = 8'h08;
  localparam logic [7:0] OFS_SAVE_PTR_LO = 8'h0c;
  localparam logic [7:0] OFS_SAVE_PTR_HI = 8'h10;
  localparam logic [7:0] OFS_LER_SRC_LO = 8'h14;
  localparam logic [7:0] OFS_LER_SRC_HI = 8'h18;
  localparam logic [7:0] OFS_LER_TGT_LO = 8'h1c;
  localparam logic [7:0] OFS_LER_TGT_HI = 8'h20;
  localparam logic [7:0] OFS_BUF_BASE_LO = 8'h24;
  localparam logic [7:0] OFS_BUF_BASE_HI = 8'h28;
  localparam logic [7:0] OFS_BUF_INDEX = 8'h2c;
  localparam logic [7:0] OFS_BUF_ABSMAX = 8'h30;
  localparam logic [7:0] OFS_BUF_THRESH = 8'h34;
  localparam logic [7:0] OFS_STACK_SEL = 8'h38;
  localparam logic [7:0] OFS_STACK_DATA = 8'h3c;
  localparam logic [7:0] OFS_STACK_TOP = 8'h40;

  // debug control field positions
  localparam int BIT_RECENT = 0;
  localparam int BIT_TRACE = 2;
  localparam int BIT_STORE = 3;
  localparam int BIT_FULLINT = 4;
  localparam logic [31:0] CTRL_WMASK = 32'h0000001d;
  localparam logic [31:0] STORE_BITS_MASK = 32'h00000018;

  // feature flag positions
  localparam int BIT_ABSENT = 11;
  localparam int BIT_SAVE_FEATURE = 21;

  // stack select field: word in [1:0], entry from bit 4 upward
  localparam int SEL_ENTRY_LSB = 4;

  // bytes taken by one record in the store buffer
  localparam logic [31:0] REC_BYTES = 32'h00000018;

  localparam logic [31:0] RST_WORD = 32'h00000000;
  localparam logic [63:0] RST_ADDR = 64'h0000000000000000;
  localparam logic [7:0] RST_SEL = 8'h00;

  typedef enum logic [1:0] {
    KIND_BRANCH = 2'h0,
    KIND_INTERRUPT = 2'h1,
    KIND_EXCEPTION = 2'h2
  } rec_kind_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SECOND = 2'b10
  } seq_state_type;

endpackage

// ==== recent_branch_stack_mem.sv ====
`timescale 1ns/10ps
module recent_branch_stack_mem #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 128,
  parameter int PTR_W = 2
) (
  input wire logic clk_sys, // system clock
  input wire logic ce, // clock enable
  input wire logic we, // write entry
  input wire logic [PTR_W-1:0] waddr, // write entry index
  input wire logic [WIDTH-1:0] wdata, // record written
  input wire logic [PTR_W-1:0] raddr, // read entry index
  output logic [WIDTH-1:0] rdata_q // registered read data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // contents need no reset: software only reads entries that were pushed
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
    end
  end

endmodule // recent_branch_stack_mem

// ==== trace_sink.sv ====
`timescale 1ns/10ps
module trace_sink (
  input wire logic clk_sys, // system clock
  input wire logic msg_valid, // bus branch message strobe
  input wire logic store_wr, // buffer write strobe
  input wire logic [63:0] rec_from, // record source
  input wire logic [63:0] rec_to, // record target
  input wire logic [1:0] rec_kind, // record kind
  input wire logic [63:0] store_addr // buffer write address
);
  // bus monitor and buffer memory kept as logs so back-to-back records keep their order
  logic [129:0] msg_log[$];
  logic [193:0] mem_log[$];
  int clash = 0;

  always @(posedge clk_sys) begin
    if (msg_valid === 1'b1) msg_log.push_back({rec_kind, rec_from, rec_to});
    if (store_wr === 1'b1) mem_log.push_back({store_addr, rec_kind, rec_from, rec_to});
    if (msg_valid === 1'b1 && store_wr === 1'b1) clash++;
  end
endmodule // trace_sink

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [31:0] ctrl; logic [4:0] f; int nm; int ns;} row_type;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mode_ext64 = 1'b0, mode_sub64 = 1'b0;
  logic br_valid = 1'b0, xc_valid = 1'b0, xc_is_int = 1'b0;
  logic [63:0] a_bf = 64'hfedcba9876543210, a_bt = 64'h123456789abcdef0;
  logic [63:0] a_xf = 64'h0f1e2d3c4b5a6978, a_xt = 64'h8877665544332211;
  logic [63:0] base = 64'h0000000100002000, e_src, rec_from, rec_to, store_addr;
  logic [31:0] reg_rdata, v;
  logic [1:0] rec_kind;
  logic ev_ready, msg_valid, store_wr, store_irq;
  logic [129:0] exp_q[$];
  int err_total = 0;
  int n_checks = 0;
  int cycles = 0;
  int m0, s0;
  // flags are {ext64, sub64, branch, event, interrupt}
  row_type rows[10] = '{'{32'h04, 5'b00100, 1, 0}, '{32'h04, 5'b11011, 1, 0},
    '{32'h04, 5'b10010, 1, 0}, '{32'h05, 5'b11110, 2, 0}, '{32'h05, 5'b01111, 2, 0},
    '{32'h00, 5'b11111, 0, 0}, '{32'h01, 5'b11100, 0, 0}, '{32'h0c, 5'b11100, 0, 1},
    '{32'h1c, 5'b11111, 0, 2}, '{32'h08, 5'b11100, 0, 0}};

  always #12.5 clk_sys = ~clk_sys;

  branch_trace_and_store_unit #(.STORE_PRESENT(1'b1), .STACK_DEPTH(4)) dut (.clk_sys(clk_sys),
    .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mode_ext64(mode_ext64), .mode_sub64(mode_sub64),
    .br_valid(br_valid), .br_from(a_bf), .br_to(a_bt), .xc_valid(xc_valid),
    .xc_is_int(xc_is_int), .xc_from(a_xf), .xc_to(a_xt), .ev_ready(ev_ready),
    .msg_valid(msg_valid), .rec_from(rec_from), .rec_to(rec_to), .rec_kind(rec_kind),
    .store_wr(store_wr), .store_addr(store_addr), .store_irq(store_irq));

  trace_sink sink (.clk_sys(clk_sys), .msg_valid(msg_valid), .store_wr(store_wr),
    .rec_from(rec_from), .rec_to(rec_to), .rec_kind(rec_kind), .store_addr(store_addr));

  function automatic logic [63:0] fmt(input logic [63:0] a);
    return (mode_ext64 === 1'b1 && mode_sub64 === 1'b1) ? a : {32'h00000000, a[31:0]};
  endfunction

  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [193:0] got, input logic [193:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    rd(a, v);
    chk(v, e);
  endtask

  // held until ev_ready is seen high, then given time for both records of a pair to land
  task automatic ev(input logic b, input logic x, input logic i);
    int k = 0;
    @(posedge clk_sys);
    br_valid <= b;
    xc_valid <= x;
    xc_is_int <= i;
    @(negedge clk_sys);
    while (ev_ready !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    @(posedge clk_sys);
    br_valid <= 1'b0;
    xc_valid <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 8000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    chk(ev_ready, 1'b1);
    rdchk(trace_store_pkg::OFS_DEBUG_CTRL, 32'h00000000);
    rd(trace_store_pkg::OFS_MISC_FEATURE, v);
    chk(v[11], 1'b0);
    rdchk(8'hfc, 32'h00000000);
    wr(trace_store_pkg::OFS_IDENT_FEATURE, 32'h00000000);
    rd(trace_store_pkg::OFS_IDENT_FEATURE, v);
    chk(v[21], 1'b1);
    wr(trace_store_pkg::OFS_DEBUG_CTRL, 32'hffffffff);
    rdchk(trace_store_pkg::OFS_DEBUG_CTRL, 32'h0000001d);
    // save area sits on a data page mapped alike for every process
    wr(trace_store_pkg::OFS_SAVE_PTR_LO, 32'h00001000);
    wr(trace_store_pkg::OFS_SAVE_PTR_HI, 32'h00000001);
    rdchk(trace_store_pkg::OFS_SAVE_PTR_LO, 32'h00001000);
    rdchk(trace_store_pkg::OFS_SAVE_PTR_HI, 32'h00000001);
    wr(trace_store_pkg::OFS_BUF_BASE_LO, base[31:0]);
    wr(trace_store_pkg::OFS_BUF_BASE_HI, base[63:32]);
    wr(trace_store_pkg::OFS_BUF_ABSMAX, 32'h00000300);
    wr(trace_store_pkg::OFS_BUF_THRESH, 32'h00000400);
    for (int r = 0; r < 10; r++) begin
      wr(trace_store_pkg::OFS_DEBUG_CTRL, rows[r].ctrl);
      mode_ext64 <= rows[r].f[4];
      mode_sub64 <= rows[r].f[3];
      m0 = sink.msg_log.size();
      s0 = sink.mem_log.size();
      ev(rows[r].f[2], rows[r].f[1], rows[r].f[0]);
      chk(sink.msg_log.size() - m0, rows[r].nm);
      chk(sink.mem_log.size() - s0, rows[r].ns);
      exp_q.delete();
      if (rows[r].f[2]) exp_q.push_back({trace_store_pkg::KIND_BRANCH, fmt(a_bf), fmt(a_bt)});
      if (rows[r].f[1]) exp_q.push_back({rows[r].f[0] ? trace_store_pkg::KIND_INTERRUPT :
        trace_store_pkg::KIND_EXCEPTION, fmt(a_xf), fmt(a_xt)});
      for (int j = 0; j < rows[r].nm; j++) chk(sink.msg_log[m0 + j], exp_q[j]);
      for (int j = 0; j < rows[r].ns; j++) chk(sink.mem_log[s0 + j][129:0], exp_q[j]);
    end
    rd(trace_store_pkg::OFS_STACK_TOP, v);
    m0 = (v + 1) & 3;
    wr(trace_store_pkg::OFS_DEBUG_CTRL, 32'h00000005);
    ev(1'b1, 1'b0, 1'b0);
    rdchk(trace_store_pkg::OFS_STACK_TOP, m0);
    wr(trace_store_pkg::OFS_STACK_SEL, m0 << 4);
    e_src = fmt(a_bf);
    rdchk(trace_store_pkg::OFS_STACK_DATA, e_src[31:0]);
    // branch alone then exception alone: the pair must keep the branch, not the event
    for (int m = 1; m < 4; m++) begin
      @(posedge clk_sys);
      mode_ext64 <= m[1];
      mode_sub64 <= m[0];
      ev(1'b1, 1'b0, 1'b0);
      ev(1'b0, 1'b1, 1'b0);
      e_src = fmt(a_bf);
      rdchk(trace_store_pkg::OFS_LER_SRC_LO, e_src[31:0]);
      rdchk(trace_store_pkg::OFS_LER_SRC_HI, e_src[63:32]);
      e_src = fmt(a_bt);
      rdchk(trace_store_pkg::OFS_LER_TGT_LO, e_src[31:0]);
      rdchk(trace_store_pkg::OFS_LER_TGT_HI, e_src[63:32]);
    end
    wr(trace_store_pkg::OFS_BUF_INDEX, 32'h00000000);
    wr(trace_store_pkg::OFS_BUF_ABSMAX, 32'h00000048);
    wr(trace_store_pkg::OFS_BUF_THRESH, 32'h00000030);
    wr(trace_store_pkg::OFS_DEBUG_CTRL, 32'h0000001c);
    s0 = sink.mem_log.size();
    // store_irq stands in for the edge-triggered counter vector that software sets up
    for (int k = 1; k < 5; k++) begin
      ev(1'b1, 1'b0, 1'b0);
      chk(store_irq, k >= 2);
    end
    chk(sink.mem_log.size() - s0, 3);
    for (int j = 0; j < 3; j++) chk(sink.mem_log[s0 + j][193:130], base + 24 * j);
    rdchk(trace_store_pkg::OFS_BUF_INDEX, 32'h00000048);
    wr(trace_store_pkg::OFS_BUF_INDEX, 32'h00000000);
    repeat (2) @(negedge clk_sys);
    chk(store_irq, 1'b0);
    wr(trace_store_pkg::OFS_BUF_THRESH, 32'h00000400);
    wr(trace_store_pkg::OFS_DEBUG_CTRL, 32'h0000000c);
    s0 = sink.mem_log.size();
    m0 = sink.msg_log.size();
    repeat (4) ev(1'b1, 1'b0, 1'b0);
    for (int j = 0; j < 4; j++) chk(sink.mem_log[s0 + j][193:130], base + 24 * (j % 3));
    chk(store_irq, 1'b0);
    chk(sink.msg_log.size() - m0, 0);
    chk(sink.clash, 0);
    // clock enable low must hold events off and freeze the index
    @(posedge clk_sys);
    ce <= 1'b0;
    br_valid <= 1'b1;
    @(negedge clk_sys);
    chk(ev_ready, 1'b0);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk(msg_valid | store_wr, 1'b0);
    @(posedge clk_sys);
    br_valid <= 1'b0;
    ce <= 1'b1;
    rdchk(trace_store_pkg::OFS_BUF_INDEX, 32'h00000018);
    give_verdict();
  end
endmodule // testbench
